// [shared/adc_seq_pkg.sv]
// Constants and types shared by the dual-slope sequencer and its helpers.
// Assumes a single 100 MHz clock and an asynchronous active-high reset.
package adc_seq_pkg;

  localparam int unsigned CLK_MHZ = 100;

  // Phase lengths in converter clocks
  localparam logic [15:0] CYCLE_LEN   = 16'h9C42;  // 40002
  localparam logic [15:0] AZ_CMD_LEN  = 16'h2711;  // 10001
  localparam logic [15:0] SI_LEN      = 16'h2710;  // 10000
  localparam logic [15:0] IZ_LEN      = 16'h00C8;  // 200
  localparam logic [15:0] IZ_OVER_LEN = 16'h1838;  // 6200
  localparam logic [14:0] OVER_COUNT  = 15'h4E20;  // 20000
  localparam logic [14:0] UNDER_COUNT = 15'h0708;  // 1800

  // Digit scan timing
  localparam logic [7:0] TOP_DIGIT_LEN = 8'hC9;    // 201
  localparam logic [7:0] DIGIT_LEN     = 8'hC8;    // 200
  localparam logic [7:0] TOP_STROBE_AT = 8'h65;    // 101
  localparam logic [7:0] STROBE_AT     = 8'h64;    // 100
  localparam logic [2:0] TOP_DIGIT     = 3'h4;

  // Least single-conversion pulse on the mode pin
  localparam int unsigned RUN_PULSE_NS  = 300;
  localparam int unsigned RUN_PULSE_CYC = (RUN_PULSE_NS * CLK_MHZ + 999) / 1000;

  // Reset values
  localparam logic RUN_HOLD_RESET = 1'b1;
  localparam logic COMP_RESET     = 1'b0;

  localparam int unsigned BUF_DEPTH = 2;

  typedef enum {PH_AZ, PH_SI, PH_DEINT, PH_IZ, PH_HOLD} phase_t;

  typedef struct packed {
    logic auto_zero;
    logic sig_int;
    logic ref_int_pos;
    logic ref_int_neg;
    logic int_zero;
  } switch_t;

  typedef struct packed {
    logic [4:0][3:0] digits;
    logic            over;
    logic            under;
    logic            polarity;
  } result_t;

  localparam int unsigned RESULT_W = $bits(result_t);

endpackage

// [rtl/pin_sync.sv]
// Three-stage synchroniser for an asynchronous pin with agreement filter.
// Assumes the pin is quasi-static relative to clk_sys.
module pin_sync #(
  parameter logic RESET_VAL = 1'b0
) (
  input  wire logic clk_sys,
  input  wire logic rst,
  input  wire logic pin,
  output logic      level
);

  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    logic level;
  } sync_state_t;

  sync_state_t s;
  sync_state_t next_s;

  always_comb begin
    next_s    = s;
    next_s.s1 = pin;
    next_s.s2 = s.s1;
    next_s.s3 = s.s2;
    // Accept a change once the later two stages agree
    if (s.s2 == s.s3) begin
      next_s.level = s.s3;
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      s <= '{s1: RESET_VAL, s2: RESET_VAL, s3: RESET_VAL, level: RESET_VAL};
    end else begin
      s <= next_s;
    end
  end

  assign level = s.level;

endmodule

// [rtl/result_buffer.sv]
// Small valid/ready buffer holding finished conversion results.
// Assumes both sides on clk_sys; full stalls the writer.
module result_buffer #(
  parameter int unsigned WIDTH = 8,
  parameter int unsigned DEPTH = 2
) (
  input  wire logic             clk_sys,
  input  wire logic             rst,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data
);

  localparam int unsigned PW = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [PW-1:0]               wr;
    logic [PW-1:0]               rd;
    logic [PW:0]                 count;
  } buf_state_t;

  buf_state_t s;
  buf_state_t next_s;
  logic       do_wr;
  logic       do_rd;

  // Count is one bit wider than the pointers so that full can be told from empty
  assign in_ready  = (s.count != (PW + 1)'(DEPTH));
  assign out_valid = (s.count != '0);
  assign out_data  = s.mem[s.rd];
  assign do_wr     = in_valid && in_ready;
  assign do_rd     = out_valid && out_ready;

  always_comb begin
    next_s = s;
    if (do_wr) begin
      next_s.mem[s.wr] = in_data;
      next_s.wr        = (s.wr == PW'(DEPTH - 1)) ? '0 : s.wr + 1'b1;
    end
    if (do_rd) begin
      next_s.rd = (s.rd == PW'(DEPTH - 1)) ? '0 : s.rd + 1'b1;
    end
    if (do_wr && !do_rd) begin
      next_s.count = s.count + 1'b1;
    end else if (do_rd && !do_wr) begin
      next_s.count = s.count - 1'b1;
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

endmodule

// [rtl/dual_slope_seq.sv]
// Dual-slope converter sequencer with multiplexed BCD digit scan.
// Assumes comparator and mode pin are asynchronous; analog switches external.
//
// What this block does
// (RL1) Phases: auto-zero, integrate, deintegrate, integrator zero.
// (RL2) Capture input sign at integrate end.
// (RL3) Count deintegration clocks as the reading.
// (RL4) Integrator zero 200 clocks, 6200 on over-range.
// (RL5) Mode high: new cycle every 40002 clocks.
// (RL6) Mode low: finish cycle, hold result.
// (RL7) Mode pulse starts one conversion after hold.
// (RL8) Commanded cycle: 10001-count auto-zero, then busy.
// (RL9) Five latch strobes per cycle, centred.
// (RL10) Top digit 201 wide, strobe at 101.
// (RL11) Other digits 200 wide, strobe at 100.
// (RL12) Keep scanning, no further strobes.
// (RL13) Busy from integrate to crossing, not auto-zero.
// (RL14) Over-range: busy until two clocks before integrator zero ends.
// (RL15) Load result first clock after busy falls.
// (RL16) Over-range beyond 20000, cleared at deintegrate.
// (RL17) Under-range at or below 1800 counts.
// (RL18) Sign high positive, valid from deintegrate.
// (RL19) Digit selects high, scanned top down.
// (RL20) Over-range blanks digits until next deintegrate.
// (RL21) BCD positive-true, zero on over-range.
// (RL22) Disable counter first deintegrate clock; auto-zero delay.
// (RL23) One switch control group per phase.
// (RL24) Top digit only zero or one.
module dual_slope_seq (
  input  wire logic               clk_sys,
  input  wire logic               rst,
  input  wire logic               run_hold,
  input  wire logic               comp,
  output adc_seq_pkg::switch_t    switches,
  output logic                    busy,
  output logic                    over_range,
  output logic                    under_range,
  output logic                    polarity,
  output logic [4:0]              digit_sel,
  output logic [3:0]              bcd,
  output logic                    latch_strobe_n
);

  typedef struct packed {
    adc_seq_pkg::phase_t  phase;
    logic [15:0]          cyc;
    logic [15:0]          pcnt;
    logic                 first;
    logic                 cmd;
    logic                 run_prev;
    logic                 sign_cap;
    logic                 over_hit;
    logic [4:0][3:0]      count;
    logic [14:0]          ref_cnt;
    logic                 busy;
    logic                 latch_pend;
    logic                 push;
    adc_seq_pkg::result_t latched;
    logic                 over;
    logic                 under;
    logic                 polarity;
    adc_seq_pkg::switch_t sw;
    logic [2:0]           dig;
    logic [7:0]           dcnt;
    logic                 burst;
    logic                 blank;
    adc_seq_pkg::result_t shown;
    logic [4:0]           digit_sel;
    logic [3:0]           bcd;
    logic                 strobe_n;
  } seq_state_t;

  seq_state_t           s;
  seq_state_t           next_s;
  logic                 run_sync;
  logic                 comp_sync;
  logic                 buf_in_ready;
  logic                 buf_out_valid;
  logic                 buf_out_ready;
  adc_seq_pkg::result_t buf_out_data;

  function automatic logic [7:0] digit_len(input logic [2:0] dig);
    return (dig == adc_seq_pkg::TOP_DIGIT) ? adc_seq_pkg::TOP_DIGIT_LEN : adc_seq_pkg::DIGIT_LEN;
  endfunction

  function automatic logic [7:0] strobe_pos(input logic [2:0] dig);
    return (dig == adc_seq_pkg::TOP_DIGIT) ? adc_seq_pkg::TOP_STROBE_AT : adc_seq_pkg::STROBE_AT;
  endfunction

  pin_sync #(.RESET_VAL(adc_seq_pkg::RUN_HOLD_RESET)) u_run_sync (
    .clk_sys (clk_sys),
    .rst     (rst),
    .pin     (run_hold),
    .level   (run_sync)
  );

  pin_sync #(.RESET_VAL(adc_seq_pkg::COMP_RESET)) u_comp_sync (
    .clk_sys (clk_sys),
    .rst     (rst),
    .pin     (comp),
    .level   (comp_sync)
  );

  // Scanner takes a new result only between strobe bursts
  assign buf_out_ready = !s.burst;

  result_buffer #(
    .WIDTH (adc_seq_pkg::RESULT_W),
    .DEPTH (adc_seq_pkg::BUF_DEPTH)
  ) u_result_buffer (
    .clk_sys   (clk_sys),
    .rst       (rst),
    .in_valid  (s.push),
    .in_ready  (buf_in_ready),
    .in_data   (s.latched),
    .out_valid (buf_out_valid),
    .out_ready (buf_out_ready),
    .out_data  (buf_out_data)
  );

  always_comb begin
    logic        carry;
    logic [15:0] iz_limit;
    logic        az_done;
    logic        deint_start;
    next_s      = s;
    carry       = 1'b1;
    deint_start = 1'b0;
    iz_limit    = s.over_hit ? adc_seq_pkg::IZ_OVER_LEN : adc_seq_pkg::IZ_LEN;
    az_done     = s.cmd ? (s.pcnt == adc_seq_pkg::AZ_CMD_LEN - 16'h0001)
                        : (s.cyc == adc_seq_pkg::CYCLE_LEN - 16'h0001);
    next_s.run_prev = run_sync;
    next_s.cyc      = s.cyc + 16'h0001;
    next_s.pcnt     = s.pcnt + 16'h0001;

    // Result latch one clock after busy falls
    if (s.latch_pend) begin
      next_s.latch_pend = 1'b0;  // see (RL15)
      next_s.latched    = '{digits: s.count, over: s.over, under: s.under, polarity: s.polarity};
    end
    if (s.push && buf_in_ready) begin
      next_s.push = 1'b0;
    end

    case (s.phase)
      adc_seq_pkg::PH_AZ: begin
        next_s.first = 1'b0;
        if (s.first) begin
          next_s.count = '0;  // see (RL22)
        end
        if (az_done) begin
          next_s.phase = adc_seq_pkg::PH_SI;  // see (RL1)
          next_s.cyc   = '0;  // see (RL5)
          next_s.pcnt  = '0;
          next_s.cmd   = 1'b0;
          next_s.busy  = 1'b1;  // see (RL8) (RL13)
          next_s.under = 1'b0;  // see (RL17)
        end
      end
      adc_seq_pkg::PH_SI: begin
        if (s.pcnt == adc_seq_pkg::SI_LEN - 16'h0001) begin
          next_s.phase    = adc_seq_pkg::PH_DEINT;
          next_s.pcnt     = '0;
          next_s.sign_cap = comp_sync;  // see (RL2)
          next_s.polarity = comp_sync;  // see (RL18)
          next_s.over     = 1'b0;  // see (RL16)
          next_s.over_hit = 1'b0;
          next_s.first    = 1'b1;
          next_s.ref_cnt  = '0;
          next_s.count    = '0;
          deint_start     = 1'b1;
        end
      end
      adc_seq_pkg::PH_DEINT: begin
        next_s.first = 1'b0;
        if (s.first) begin
          next_s.first = 1'b0;  // see (RL22)
        end else if (comp_sync != s.sign_cap) begin
          next_s.busy       = 1'b0;  // see (RL13)
          next_s.latch_pend = 1'b1;
          next_s.under      = (s.ref_cnt <= adc_seq_pkg::UNDER_COUNT);  // see (RL17)
          next_s.phase      = adc_seq_pkg::PH_IZ;
          next_s.pcnt       = '0;
        end else if (s.ref_cnt == adc_seq_pkg::OVER_COUNT) begin
          next_s.over_hit = 1'b1;  // see (RL16)
          next_s.phase    = adc_seq_pkg::PH_IZ;
          next_s.pcnt     = '0;
        end else begin
          next_s.ref_cnt = s.ref_cnt + 15'h0001;  // see (RL3)
          for (int i = 0; i < 5; i++) begin
            if (carry) begin
              if (s.count[i] == 4'h9 || (i == 4 && s.count[i] == 4'h1)) begin
                next_s.count[i] = 4'h0;  // see (RL24)
              end else begin
                next_s.count[i] = s.count[i] + 4'h1;
                carry           = 1'b0;
              end
            end
          end
        end
      end
      adc_seq_pkg::PH_IZ: begin
        // Over-range busy falls two clocks early so the latch fits inside the phase
        if (s.busy && s.pcnt >= iz_limit - 16'h0003) begin
          next_s.busy       = 1'b0;  // see (RL14)
          next_s.over       = 1'b1;  // see (RL16)
          next_s.under      = 1'b0;
          next_s.latch_pend = 1'b1;
        end
        if (s.pcnt >= iz_limit - 16'h0001) begin  // see (RL4)
          next_s.pcnt = s.pcnt;
          if (!s.busy && !s.push && !s.latch_pend) begin
            next_s.push  = 1'b1;
            next_s.pcnt  = '0;
            next_s.first = 1'b1;
            next_s.phase = run_sync ? adc_seq_pkg::PH_AZ : adc_seq_pkg::PH_HOLD;  // see (RL6)
          end
        end
      end
      adc_seq_pkg::PH_HOLD: begin
        if (run_sync && !s.run_prev) begin
          next_s.phase = adc_seq_pkg::PH_AZ;  // see (RL7)
          next_s.cmd   = 1'b1;  // see (RL8)
          next_s.pcnt  = '0;
          next_s.first = 1'b1;
        end
      end
      default: begin
        next_s.phase = adc_seq_pkg::PH_AZ;
      end
    endcase

    // Analog switch controls, one group per phase
    next_s.sw             = '0;
    next_s.sw.auto_zero   = (next_s.phase == adc_seq_pkg::PH_AZ) || (next_s.phase == adc_seq_pkg::PH_HOLD);  // see (RL23)
    next_s.sw.sig_int     = (next_s.phase == adc_seq_pkg::PH_SI);
    next_s.sw.ref_int_pos = (next_s.phase == adc_seq_pkg::PH_DEINT) && next_s.sign_cap;
    next_s.sw.ref_int_neg = (next_s.phase == adc_seq_pkg::PH_DEINT) && !next_s.sign_cap;
    next_s.sw.int_zero    = (next_s.phase == adc_seq_pkg::PH_IZ);

    // Digit scan and strobe burst
    if (buf_out_valid && buf_out_ready) begin
      next_s.shown = buf_out_data;
      next_s.burst = 1'b1;  // see (RL9)
      next_s.blank = 1'b0;
      next_s.dig   = adc_seq_pkg::TOP_DIGIT;  // see (RL10)
      next_s.dcnt  = '0;
    end else begin
      next_s.dcnt = s.dcnt + 8'h01;
      if (s.burst && s.dig == 3'h0 && s.dcnt == strobe_pos(s.dig)) begin
        next_s.burst = 1'b0;  // see (RL12)
        next_s.blank = s.shown.over;  // see (RL20)
      end
      if (s.dcnt == digit_len(s.dig) - 8'h01) begin
        next_s.dcnt = '0;
        next_s.dig  = (s.dig == 3'h0) ? adc_seq_pkg::TOP_DIGIT : s.dig - 3'h1;  // see (RL19) (RL11)
      end
    end
    if (deint_start) begin
      next_s.blank = 1'b0;  // see (RL20)
    end

    // Registered outputs follow the scanner one clock later
    next_s.digit_sel = s.blank ? 5'h00 : 5'(5'h01 << s.dig);  // see (RL19)
    next_s.bcd       = (s.blank || s.shown.over) ? 4'h0 : s.shown.digits[s.dig];  // see (RL21)
    next_s.strobe_n  = !(s.burst && s.dcnt == strobe_pos(s.dig));  // see (RL9) (RL10) (RL11)
    // One dark clock before a new result so the top select always rises afresh
    if (buf_out_valid && buf_out_ready) begin
      next_s.digit_sel = 5'h00;  // see (RL10)
      next_s.bcd       = 4'h0;
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      s          <= '0;
      s.phase    <= adc_seq_pkg::PH_AZ;
      s.first    <= 1'b1;
      s.run_prev <= adc_seq_pkg::RUN_HOLD_RESET;
      s.dig      <= adc_seq_pkg::TOP_DIGIT;
      s.strobe_n <= 1'b1;
      s.sw       <= '{auto_zero: 1'b1, default: 1'b0};
    end else begin
      s <= next_s;
    end
  end

  assign switches       = s.sw;
  assign busy           = s.busy;
  assign over_range     = s.over;
  assign under_range    = s.under;
  assign polarity       = s.polarity;
  assign digit_sel      = s.digit_sel;
  assign bcd            = s.bcd;
  assign latch_strobe_n = s.strobe_n;

endmodule

// [tb/dual_slope_seq_chk.sv]
// Port checker for the dual-slope sequencer, bound to its top module.
// Assumes one clock domain, clk_sys, with asynchronous reset rst.
module dual_slope_seq_chk (
  input wire logic                 clk_sys,
  input wire logic                 rst,
  input wire logic                 run_hold,
  input wire logic                 comp,
  input wire adc_seq_pkg::switch_t switches,
  input wire logic                 busy,
  input wire logic                 over_range,
  input wire logic                 under_range,
  input wire logic                 polarity,
  input wire logic [4:0]           digit_sel,
  input wire logic [3:0]           bcd,
  input wire logic                 latch_strobe_n
);
  logic [15:0] si_cnt;
  logic [15:0] iz_cnt;

  // Clocks spent so far in integrate and integrator zero
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      si_cnt <= 16'h0000;
      iz_cnt <= 16'h0000;
    end else begin
      si_cnt <= switches.sig_int ? si_cnt + 16'h0001 : 16'h0000;
      iz_cnt <= switches.int_zero ? iz_cnt + 16'h0001 : 16'h0000;
    end
  end

  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);

  one_phase_a: assert property ($onehot(switches))
    else $error("switch controls not one-hot");
  si_len_a: assert property ($fell(switches.sig_int) |-> si_cnt == adc_seq_pkg::SI_LEN)
    else $error("integrate length wrong");
  iz_len_a: assert property ($fell(switches.int_zero) |-> iz_cnt == 16'h00C8 || iz_cnt == 16'h1838)
    else $error("integrator zero length wrong");
  busy_start_a: assert property ($rose(switches.sig_int) |-> $rose(busy))
    else $error("busy not raised at integrate start");
  over_set_a: assert property ($rose(over_range) |-> $fell(busy))
    else $error("over flag set away from busy fall");
  over_clr_a: assert property ($fell(over_range) |-> $rose(switches.ref_int_pos | switches.ref_int_neg))
    else $error("over flag cleared away from deintegrate start");
  under_set_a: assert property ($rose(under_range) |-> $fell(busy))
    else $error("under flag set away from busy fall");
  under_clr_a: assert property ($fell(under_range) |-> $rose(switches.sig_int))
    else $error("under flag cleared away from integrate start");
  sign_hold_a: assert property ($changed(polarity) |-> $rose(switches.ref_int_pos | switches.ref_int_neg))
    else $error("sign changed outside deintegrate start");
  strobe_one_a: assert property (!latch_strobe_n |-> $onehot(digit_sel) ##1 latch_strobe_n)
    else $error("strobe not a single clock within a digit");
  top_strobe_a: assert property (!latch_strobe_n && digit_sel[4] |->
    $past(digit_sel, 101) == digit_sel && $past(digit_sel, 102) != digit_sel)
    else $error("top digit strobe misplaced");
  low_strobe_a: assert property (!latch_strobe_n && !digit_sel[4] |->
    $past(digit_sel, 100) == digit_sel && $past(digit_sel, 101) != digit_sel)
    else $error("digit strobe misplaced");
  scan_order_a: assert property (digit_sel != 5'h00 && $past(digit_sel) != 5'h00 && $changed(digit_sel) |->
    digit_sel == {$past(digit_sel[0]), $past(digit_sel[4:1])})
    else $error("digit scan order wrong");
  blank_bcd_a: assert property (digit_sel == 5'h00 |-> bcd == 4'h0)
    else $error("data active without digit select");
  top_value_a: assert property (digit_sel[4] |-> bcd <= 4'h1)
    else $error("top digit above one");

  cover property ($rose(busy));
  cover property ($rose(over_range));
  cover property (!latch_strobe_n && digit_sel[0]);
endmodule

bind dual_slope_seq dual_slope_seq_chk i_chk (.clk_sys, .rst, .run_hold, .comp, .switches, .busy, .over_range,
  .under_range, .polarity, .digit_sel, .bcd, .latch_strobe_n);

// [tb/result_latch.sv]
// Host-side result latch fed by the multiplexed digit scan.
// Assumes one-hot digit selects and a one-clock active-low strobe.
module result_latch (
  input wire logic        clk_sys,
  input wire logic [4:0]  digit_sel,
  input wire logic [3:0]  bcd,
  input wire logic        latch_strobe_n,
  output logic [4:0][3:0] digits,
  output int              strobes
);
  timeunit 1ns;
  timeprecision 1ps;

  initial strobes = 0;

  // Capture the selected digit on each strobe
  always @(posedge clk_sys) begin
    if (latch_strobe_n === 1'b0) begin
      strobes <= strobes + 1;
      for (int i = 0; i < 5; i++) begin
        if (digit_sel[i]) begin
          digits[i] <= bcd;
        end
      end
    end
  end
endmodule

// [tb/tb_dual_slope_adc_sequencer_bcd_scan.sv]
// Bench for the sequencer: a continuous cycle, hold, then a commanded over-range cycle.
// Assumes the result latch model on the scan outputs; comp stands in for the comparator.
module tb_dual_slope_adc_sequencer_bcd_scan;
  timeunit 1ns;
  timeprecision 1ps;

  logic                 clk_sys;
  logic                 rst;
  logic                 run_hold;
  logic                 comp;
  adc_seq_pkg::switch_t switches;
  logic                 busy;
  logic                 over_range;
  logic                 under_range;
  logic                 polarity;
  logic [4:0]           digit_sel;
  logic [3:0]           bcd;
  logic                 latch_strobe_n;
  logic [4:0][3:0]      held;
  int                   strobes;
  int                   err_count;
  int                   checks;
  int                   cycles;

  dual_slope_seq i_dut (.clk_sys, .rst, .run_hold, .comp, .switches, .busy, .over_range, .under_range,
    .polarity, .digit_sel, .bcd, .latch_strobe_n);
  result_latch i_host (.clk_sys, .digit_sel, .bcd, .latch_strobe_n, .digits(held), .strobes);

  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  // Both cycles take about 113000 clocks
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 130000) begin
      err_count++;
      conclude();
    end
  end

  task automatic compare(input logic [19:0] got, input logic [19:0] exp);
    checks++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] t=%0t got=%0h exp=%0h", $time, got, exp);
    end
  endtask

  task automatic conclude;
    if (err_count == 0 && checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic check_reset;
    compare({1'b0, switches, busy, over_range, under_range, polarity, latch_strobe_n, digit_sel, bcd},
      {1'b0, 5'h10, 4'h0, 1'b1, 9'h000});
  endtask

  task automatic normal_cycle;
    int n;
    int s0;
    for (n = 0; n < 40100 && busy !== 1'b1; n++) @(negedge clk_sys);
    compare({19'h0, n > 39999 && n < 40010}, 20'h00001);
    compare({15'h0, switches}, 20'h00008);
    run_hold = 1'b0;
    for (n = 0; n < 10100 && switches.ref_int_pos !== 1'b1; n++) @(negedge clk_sys);
    compare({13'h0, switches, polarity, n > 9990 && n < 10010}, {13'h0, 5'h04, 2'h3});
    repeat (12343) @(negedge clk_sys);
    comp = 1'b0;
    for (n = 0; n < 100 && busy !== 1'b0; n++) @(negedge clk_sys);
    compare({17'h0, busy, over_range, under_range}, 20'h00000);
    s0 = strobes;
    for (n = 0; n < 2000 && strobes < s0 + 5; n++) @(negedge clk_sys);
    compare({4'h0, held[4:1]}, 20'h01234);
    repeat (2000) @(negedge clk_sys);
    compare({14'h0, busy, switches}, {14'h0, 1'b0, 5'h10});
    compare(20'(strobes - s0), 20'h00005);
  endtask

  task automatic over_cycle;
    int n;
    int s0;
    run_hold = 1'b1;
    repeat (40) @(negedge clk_sys);
    run_hold = 1'b0;
    for (n = 40; n < 10100 && busy !== 1'b1; n++) @(negedge clk_sys);
    compare({19'h0, n > 10000 && n < 10012}, 20'h00001);
    for (n = 0; n < 10100 && switches.ref_int_neg !== 1'b1; n++) @(negedge clk_sys);
    compare({14'h0, switches, polarity}, {14'h0, 5'h02, 1'b0});
    for (n = 0; n < 26400 && busy !== 1'b0; n++) @(negedge clk_sys);
    compare({17'h0, busy, over_range, n > 26190 && n < 26215}, 20'h00003);
    s0 = strobes;
    for (n = 0; n < 2000 && strobes < s0 + 5; n++) @(negedge clk_sys);
    compare(held, 20'h00000);
    repeat (50) @(negedge clk_sys);
    compare({11'h0, digit_sel, bcd}, 20'h00000);
  endtask

  initial begin
    rst = 1'b1;
    run_hold = 1'b1;
    comp = 1'b1;
    repeat (3) @(negedge clk_sys);
    check_reset();
    rst = 1'b0;
    normal_cycle();
    over_cycle();
    conclude();
  end
endmodule
